// >>> design/rta_alarm_irq.sv
// rtc alarm compare, event flags, cpu interrupt, wake pin and resets
// assumes time counters outside supply cur_time and a one-cycle ms_tick
// Functional notes
// - millisecond alarm is 1+4+4+4 bit bcd, 0000-1023, invalid never matches.
// - second alarm is 3+4 bit bcd, 00-59, invalid never matches.
// - minute alarm is 3+4 bit bcd, 00-59, invalid never matches.
// - hour alarm is 2+4 bit bcd up to 23, invalid never matches.
// - day alarm is 2+4 bit bcd, 01-31, invalid never matches.
// - month alarm is 1+4 bit bcd, 01-12, invalid never matches.
// - year alarm is 4+4 bit bcd, 00-99, invalid never matches.
// - load strobe copies all buffered alarm fields together in one cycle.
// - alarm registers always readable, never changed by counting.
// - alarm, periodic and wake events merge into one interrupt line.
// - interrupt reaches cpu only while gate bit 0 is set.
// - any pending event also forces the master clock gate open.
// - enabled event sets its flag; writing one clears it.
// - power loss flag; accesses wait three cycles after power-up.
// - interrupt stays asserted while gate bit 0 is set and any flag remains set.
// - enable bits 0..4 select ms, second, minute, hour, day events.
// - periodic event fires when its unit increments, flag sticks.
// - alarm event on equal time, enable bit 15, flag bit 15.
// - wake ungates clock at once, alarm via its flag one cycle after the match; cause stays latched.
// - supply monitor reset restores all defaults; soft reset bit does too but clears the power loss flag.
// - millisecond count rolls over after 1023 and advances seconds.
// - wake pin rising edge sets flag; ungating follows the level; both only while the pin is an input.
module rta_alarm_irq
  import rta_pkg::*;
(
  input wire logic clk,
  input wire logic clk_en,
  input wire logic sys_rst,
  input wire rta_apb_req_t apb_req,
  output rta_apb_rsp_t apb_rsp,
  input wire logic ms_tick,
  input wire rta_time_t cur_time,
  input wire logic wake_i,
  output logic wake_o,
  output logic wake_oe,
  output logic cpu_irq,
  output logic clk_ungate
);

  // address decode shared by reads and writes
  function automatic rta_sel_t reg_sel(input logic [15:0] a);
    rta_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'b00) begin
      case (a[15:2])
        IDX_IRQ_GATE: s = SEL_GATE;
        IDX_SHADOW: s = SEL_SHADOW;
        IDX_A_MS: s = SEL_A_MS;
        IDX_A_SEC: s = SEL_A_SEC;
        IDX_A_MIN: s = SEL_A_MIN;
        IDX_A_HOUR: s = SEL_A_HOUR;
        IDX_A_DAY: s = SEL_A_DAY;
        IDX_A_MON: s = SEL_A_MON;
        IDX_A_YEAR: s = SEL_A_YEAR;
        IDX_FLAG: s = SEL_FLAG;
        IDX_PWR_LOSS: s = SEL_PWR;
        IDX_EV_EN: s = SEL_EV_EN;
        IDX_OSC: s = SEL_OSC;
        IDX_PMGT: s = SEL_PMGT;
        default: s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : reg_sel

  // one bcd digit holds 0 to 9
  function automatic logic dig_ok(input logic [3:0] d);
    return d <= BCD_MAX;
  endfunction : dig_ok

  // state
  logic gate_q, gate_d;
  logic load_q, load_d;
  logic soft_q, soft_d;
  logic dir_q, dir_d;
  logic pwr_q, pwr_d;
  logic [15:0] en_q, en_d;
  logic [15:0] flag_q, flag_d;
  rta_time_t buf_q, buf_d;
  rta_time_t act_q, act_d;
  rta_time_t prev_q, prev_d;
  logic tick_q, tick_d;
  logic wake_q, wake_d;
  logic [1:0] hold_q, hold_d;
  logic [31:0] prdata_q, prdata_d;

  // combinational helpers
  rta_sel_t sel;
  logic pready;
  logic wr;
  logic [15:0] wdat;
  logic [15:0] rdat;
  logic [15:0] set_v;
  logic [15:0] clr_v;
  logic alarm_ok;
  logic alarm_hit;
  logic ms_wrap;
  logic wake_rise;

  // bus handshake; stalls while the post-reset hold runs
  assign sel = reg_sel(apb_req.paddr);
  assign pready = apb_req.psel & apb_req.penable & clk_en
                & (hold_q == 2'd0);
  assign wr = pready & apb_req.pwrite;
  assign wdat = apb_req.pwdata[15:0];
  assign apb_rsp.pready = pready;
  assign apb_rsp.prdata = prdata_q;
  assign apb_rsp.pslverr = pready & (sel == SEL_NONE);

  // read mux, alarm values come from the buffers
  always_comb begin
    rdat = 16'h0000;
    case (sel)
      SEL_GATE: rdat[GATE_BIT] = gate_q;
      SEL_SHADOW: rdat[LOAD_BIT] = load_q;
      SEL_A_MS: rdat = 16'(buf_q.ms);
      SEL_A_SEC: rdat = 16'(buf_q.sec);
      SEL_A_MIN: rdat = 16'(buf_q.min);
      SEL_A_HOUR: rdat = 16'(buf_q.hour);
      SEL_A_DAY: rdat = 16'(buf_q.day);
      SEL_A_MON: rdat = 16'(buf_q.mon);
      SEL_A_YEAR: rdat = 16'(buf_q.year);
      SEL_FLAG: rdat = flag_q;
      SEL_PWR: rdat[0] = pwr_q;
      SEL_EV_EN: rdat = en_q;
      SEL_OSC: rdat[SRST_BIT] = soft_q;
      SEL_PMGT: rdat[DIR_BIT] = dir_q;
      default: rdat = 16'h0000;
    endcase
  end

  // read data and access hold
  always_comb begin
    prdata_d = prdata_q;
    if (apb_req.psel) begin
      prdata_d = {16'h0000, rdat};
    end
    hold_d = hold_q;
    if (soft_q) begin
      hold_d = SYNC_CYCLES;
    end else if (hold_q != 2'd0) begin
      hold_d = hold_q - 2'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prdata_q <= 32'h0000_0000;
      hold_q <= SYNC_CYCLES;
    end else if (clk_en) begin
      prdata_q <= prdata_d;
      hold_q <= hold_d;
    end
  end

  // register file: gate, strobe, buffers, active alarm, enables
  always_comb begin
    gate_d = gate_q;
    load_d = 1'b0;
    soft_d = 1'b0;
    dir_d = dir_q;
    pwr_d = pwr_q;
    en_d = en_q;
    buf_d = buf_q;
    act_d = act_q;
    if (load_q) begin
      act_d = buf_q;
    end
    if (wr) begin
      case (sel)
        SEL_GATE: gate_d = wdat[GATE_BIT];
        SEL_SHADOW: load_d = wdat[LOAD_BIT];
        SEL_A_MS: buf_d.ms = wdat[12:0];
        SEL_A_SEC: buf_d.sec = wdat[6:0];
        SEL_A_MIN: buf_d.min = wdat[6:0];
        SEL_A_HOUR: buf_d.hour = wdat[5:0];
        SEL_A_DAY: buf_d.day = wdat[5:0];
        SEL_A_MON: buf_d.mon = wdat[4:0];
        SEL_A_YEAR: buf_d.year = wdat[7:0];
        SEL_EV_EN: en_d = wdat & EV_MASK;
        SEL_OSC: soft_d = wdat[SRST_BIT];
        SEL_PMGT: dir_d = wdat[DIR_BIT];
        default: gate_d = gate_q;
      endcase
    end
    // soft reset restores defaults and clears the power loss flag
    if (soft_q) begin
      gate_d = 1'b0;
      load_d = 1'b0;
      dir_d = 1'b0;
      pwr_d = 1'b0;
      en_d = EV_EN_RST;
      buf_d = '0;
      act_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gate_q <= 1'b0;
      load_q <= 1'b0;
      soft_q <= 1'b0;
      dir_q <= 1'b0;
      pwr_q <= 1'b1;
      en_q <= EV_EN_RST;
      buf_q <= '0;
      act_q <= '0;
    end else if (clk_en) begin
      gate_q <= gate_d;
      load_q <= load_d;
      soft_q <= soft_d;
      dir_q <= dir_d;
      pwr_q <= pwr_d;
      en_q <= en_d;
      buf_q <= buf_d;
      act_q <= act_d;
    end
  end

  // active alarm must be legal bcd in range to ever match
  always_comb begin
    alarm_ok = 1'b1;
    if (!dig_ok(act_q.ms[11:8]) || !dig_ok(act_q.ms[7:4])
        || !dig_ok(act_q.ms[3:0]) || act_q.ms > MS_TOP) begin
      alarm_ok = 1'b0;
    end
    if (!dig_ok(act_q.sec[3:0]) || act_q.sec > SEC_TOP) begin
      alarm_ok = 1'b0;
    end
    if (!dig_ok(act_q.min[3:0]) || act_q.min > MIN_TOP) begin
      alarm_ok = 1'b0;
    end
    if (!dig_ok(act_q.hour[3:0]) || act_q.hour > HOUR_TOP) begin
      alarm_ok = 1'b0;
    end
    if (!dig_ok(act_q.day[3:0]) || act_q.day > DAY_TOP
        || act_q.day == 6'h00) begin
      alarm_ok = 1'b0;
    end
    if (!dig_ok(act_q.mon[3:0]) || act_q.mon > MON_TOP
        || act_q.mon == 5'h00) begin
      alarm_ok = 1'b0;
    end
    if (!dig_ok(act_q.year[7:4]) || !dig_ok(act_q.year[3:0])) begin
      alarm_ok = 1'b0;
    end
  end

  // compare in the cycle after the tick, once per millisecond
  assign alarm_hit = tick_q & alarm_ok & (cur_time == act_q);
  // millisecond wrap from top to zero also counts as a second step
  assign ms_wrap = (prev_q.ms == MS_TOP) & (cur_time.ms == 13'h0000);
  // wake edge only while the pin is an input
  assign wake_rise = wake_i & ~wake_q & ~dir_q;

  // hardware event vector, gated by the enables
  always_comb begin
    set_v = 16'h0000;
    set_v[EV_MS] = tick_q;
    set_v[EV_SEC] = tick_q & ((cur_time.sec != prev_q.sec) | ms_wrap);
    set_v[EV_MIN] = tick_q & (cur_time.min != prev_q.min);
    set_v[EV_HOUR] = tick_q & (cur_time.hour != prev_q.hour);
    set_v[EV_DAY] = tick_q & (cur_time.day != prev_q.day);
    set_v[EV_EXT] = wake_rise;
    set_v[EV_ALARM] = alarm_hit;
    set_v = set_v & en_q;
  end

  // sticky flags, write one to clear, set wins
  always_comb begin
    clr_v = 16'h0000;
    if (wr && sel == SEL_FLAG) begin
      clr_v = wdat & EV_MASK;
    end
    flag_d = (flag_q & ~clr_v) | set_v;
    tick_d = ms_tick;
    prev_d = tick_q ? cur_time : prev_q;
    wake_d = wake_i;
    if (soft_q) begin
      flag_d = FLAG_RST;
      tick_d = 1'b0;
      prev_d = '0;
      wake_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_q <= FLAG_RST;
      tick_q <= 1'b0;
      prev_q <= '0;
      wake_q <= 1'b0;
    end else if (clk_en) begin
      flag_q <= flag_d;
      tick_q <= tick_d;
      prev_q <= prev_d;
      wake_q <= wake_d;
    end
  end

  // one merged request, gated toward the cpu
  assign cpu_irq = gate_q & (|flag_q);
  // pending events and a high input pin open the master clock gate
  assign clk_ungate = (|flag_q) | (wake_i & ~dir_q);
  // output mode pulls the pin low only while no event is pending
  assign wake_o = 1'b0;
  assign wake_oe = dir_q & ~(|flag_q);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_gate_blocks: assert property (!gate_q |-> !cpu_irq)
    else $error("irq seen while gate bit is clear");

  chk_irq_held: assert property (
    (clk_en && !soft_q && gate_q && flag_q != 16'h0000
     && !(wr && sel == SEL_FLAG) && !(wr && sel == SEL_GATE))
    |=> cpu_irq && clk_ungate)
    else $error("irq dropped while a flag is set");

  chk_flag_sticky: assert property (
    (clk_en && !soft_q && flag_q[EV_SEC] && !(wr && sel == SEL_FLAG))
    |=> flag_q[EV_SEC])
    else $error("periodic flag dropped without a clear");

  chk_alarm_load: assert property (
    (clk_en && load_q && !soft_q) |=> act_q == $past(buf_q))
    else $error("alarm set not loaded from buffers");

  chk_alarm_invalid: assert property (
    (clk_en && !soft_q && !alarm_ok && !flag_q[EV_ALARM])
    |=> !flag_q[EV_ALARM])
    else $error("invalid alarm setting raised the alarm flag");

  chk_w1c_clear: assert property (
    (clk_en && !soft_q && wr && sel == SEL_FLAG && wdat[EV_SEC]
     && !set_v[EV_SEC]) |=> !flag_q[EV_SEC])
    else $error("write one did not clear the flag");

  chk_set_wins: assert property (
    (clk_en && !soft_q && set_v[EV_ALARM]) |=> flag_q[EV_ALARM])
    else $error("hardware set lost to a clear");

  chk_startup_stall: assert property (
    (hold_q != 2'd0) |-> !apb_rsp.pready)
    else $error("access answered during the hold");

  chk_soft_reset: assert property (
    (clk_en && soft_q) |=> flag_q == FLAG_RST && !gate_q
      && en_q == EV_EN_RST && hold_q == SYNC_CYCLES && !pwr_q)
    else $error("soft reset left state behind");

  chk_wake_ungate: assert property (
    (wake_i && !dir_q) |-> clk_ungate)
    else $error("high wake pin did not ungate the clock");

  chk_alarm_tick: assert property (
    (clk_en && !soft_q && !tick_q && !flag_q[EV_ALARM])
    |=> !flag_q[EV_ALARM])
    else $error("alarm flag set outside a tick");

  cov_alarm_fire: cover property (clk_en && alarm_hit && en_q[EV_ALARM]);
  cov_wake_event: cover property (clk_en && set_v[EV_EXT]);
  cov_sec_event: cover property (clk_en && set_v[EV_SEC] && ms_wrap);
  cov_soft_reset: cover property (clk_en && soft_q ##1 hold_q != 2'd0);
  cov_set_clear_tie: cover property (clk_en && set_v[EV_SEC] && clr_v[EV_SEC]);

endmodule : rta_alarm_irq

// >>> design/rta_pkg.sv
// constants and types of the rtc alarm, event flag and wake block
// assumes one clock; registers sit at word index * 4 on an apb bus
package rta_pkg;
  // clock rate and the post-reset access hold in clock cycles
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam logic [1:0] SYNC_CYCLES = 2'd3;
  // register indexes; byte address is index * 4
  localparam logic [13:0] IDX_IRQ_GATE = 14'h1900;
  localparam logic [13:0] IDX_SHADOW = 14'h1901;
  localparam logic [13:0] IDX_A_MS = 14'h1905;
  localparam logic [13:0] IDX_A_SEC = 14'h1909;
  localparam logic [13:0] IDX_A_MIN = 14'h190d;
  localparam logic [13:0] IDX_A_HOUR = 14'h1911;
  localparam logic [13:0] IDX_A_DAY = 14'h1915;
  localparam logic [13:0] IDX_A_MON = 14'h1919;
  localparam logic [13:0] IDX_A_YEAR = 14'h191d;
  localparam logic [13:0] IDX_FLAG = 14'h1920;
  localparam logic [13:0] IDX_PWR_LOSS = 14'h1921;
  localparam logic [13:0] IDX_EV_EN = 14'h1924;
  localparam logic [13:0] IDX_OSC = 14'h192c;
  localparam logic [13:0] IDX_PMGT = 14'h1930;
  // field positions
  localparam int GATE_BIT = 0;
  localparam int LOAD_BIT = 14;
  localparam int SRST_BIT = 0;
  localparam int DIR_BIT = 0;
  localparam int EV_MS = 0;
  localparam int EV_SEC = 1;
  localparam int EV_MIN = 2;
  localparam int EV_HOUR = 3;
  localparam int EV_DAY = 4;
  localparam int EV_EXT = 14;
  localparam int EV_ALARM = 15;
  localparam logic [15:0] EV_MASK = 16'hc01f;
  // bcd limits of the alarm fields
  localparam logic [12:0] MS_TOP = 13'h1023;
  localparam logic [6:0] SEC_TOP = 7'h59;
  localparam logic [6:0] MIN_TOP = 7'h59;
  localparam logic [5:0] HOUR_TOP = 6'h23;
  localparam logic [5:0] DAY_TOP = 6'h31;
  localparam logic [4:0] MON_TOP = 5'h12;
  localparam logic [7:0] YEAR_TOP = 8'h99;
  localparam logic [3:0] BCD_MAX = 4'h9;
  // reset values
  localparam logic [15:0] EV_EN_RST = 16'h0000;
  localparam logic [15:0] FLAG_RST = 16'h0000;

  // bcd time and calendar value
  typedef struct packed {
    logic [12:0] ms;
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic [5:0] day;
    logic [4:0] mon;
    logic [7:0] year;
  } rta_time_t;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } rta_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } rta_apb_rsp_t;

  // register selected by an address
  typedef enum {
    SEL_NONE, SEL_GATE, SEL_SHADOW, SEL_A_MS, SEL_A_SEC, SEL_A_MIN,
    SEL_A_HOUR, SEL_A_DAY, SEL_A_MON, SEL_A_YEAR, SEL_FLAG, SEL_PWR,
    SEL_EV_EN, SEL_OSC, SEL_PMGT
  } rta_sel_t;
endpackage : rta_pkg

// >>> tb/rta_host_model.sv
// host side model: cpu interrupt input and master clock gater
// assumes level request and ungate outputs of the rtc block, one clock
module rta_host_model
  import rta_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cpu_irq,
  input wire logic clk_ungate,
  output logic irq_latched,
  output logic clk_on
);
  timeunit 1ns;
  timeprecision 1ps;

  // gater opens at once on the ungate level, no clock involved
  assign clk_on = clk_ungate;

  // cpu side holds the request so the cause can be read later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_latched <= 1'b0;
    end else if (cpu_irq) begin
      irq_latched <= 1'b1;
    end
  end
endmodule : rta_host_model

// >>> tb/tb_rta_alarm_irq.sv
// testbench of the alarm, event flag and wake block
// assumes apb answers with pready and a host model on the request lines
module tb_rta_alarm_irq;
  import rta_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ms_tick = 1'b0;
  logic wake_i = 1'b0;
  rta_apb_req_t apb_req = '0;
  rta_apb_rsp_t apb_rsp;
  rta_time_t cur_time = '0;
  logic wake_o, wake_oe, cpu_irq, clk_ungate, irq_latched, clk_on;
  logic [31:0] rd;
  logic slv;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] t [7];
  logic [15:0] good [7] = '{16'h0, 16'h46, 16'h18, 16'h03, 16'h07,
                            16'h05, 16'h10};
  logic [15:0] bad [7] = '{16'h1024, 16'h5a, 16'h60, 16'h24, 16'h32,
                           16'h13, 16'h9a};

  // clock
  always #5 clk = ~clk;

  rta_alarm_irq uut (
    .clk(clk), .clk_en(1'b1), .sys_rst(sys_rst), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .ms_tick(ms_tick), .cur_time(cur_time),
    .wake_i(wake_i), .wake_o(wake_o), .wake_oe(wake_oe),
    .cpu_irq(cpu_irq), .clk_ungate(clk_ungate)
  );

  rta_host_model host (
    .clk(clk), .sys_rst(sys_rst), .cpu_irq(cpu_irq),
    .clk_ungate(clk_ungate), .irq_latched(irq_latched), .clk_on(clk_on)
  );

  // verdict and end of run
  task close_out;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  // word compare
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t word got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // pin compare
  task chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t pin got %b exp %b", $time, got, exp);
    end
  endtask : chk1

  // one apb transfer, held until pready is seen at a rising edge
  task apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    @(posedge clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= {idx, 2'b00};
    apb_req.pwdata <= wd;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // wait for the answer; only the cycle ceiling ends a hang
    do begin
      @(posedge clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    slv = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task wr(input logic [13:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task rdc(input logic [13:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask : rdc

  // one millisecond tick pulse, then settle
  task tick;
    @(posedge clk);
    ms_tick <= 1'b1;
    @(posedge clk);
    ms_tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : tick

  function automatic rta_time_t pack_t();
    return {t[0][12:0], t[1][6:0], t[2][6:0], t[3][5:0], t[4][5:0],
            t[5][4:0], t[6][7:0]};
  endfunction : pack_t

  // program the alarm, one field out of range unless k is 7
  task arm(input int k);
    t = good;
    if (k < 7) t[k] = bad[k];
    for (int i = 0; i < 7; i++) begin
      wr(IDX_A_MS + 14'(4 * i), {16'h0, t[i]});
    end
    wr(IDX_SHADOW, 32'h0000_4000);
    cur_time <= pack_t();
    tick;
  endtask : arm

  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      close_out;
    end
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(IDX_PWR_LOSS, 32'h1);
    rdc(IDX_EV_EN, {16'h0, EV_EN_RST});
    rdc(IDX_FLAG, {16'h0, FLAG_RST});
    apb(1'b0, 14'h1904, 32'h0);
    chk1(slv, 1'b1);
    wr(IDX_A_SEC, 32'hffff_ff46);
    rdc(IDX_A_SEC, 32'h46);
    wr(IDX_IRQ_GATE, 32'h1);
    wr(IDX_EV_EN, 32'h8000);
    for (int k = 0; k < 7; k++) begin
      arm(k);
      rdc(IDX_FLAG, 32'h0);
    end
    arm(7);
    rdc(IDX_FLAG, 32'h8000);
    #1 chk1(cpu_irq, 1'b1);
    chk1(irq_latched, 1'b1);
    chk1(clk_on, 1'b1);
    wr(IDX_FLAG, 32'h8000);
    rdc(IDX_FLAG, 32'h0);
    #1 chk1(cpu_irq, 1'b0);
    // periodic events, millisecond one left disabled
    wr(IDX_EV_EN, 32'h1e);
    for (int k = 0; k < 5; k++) begin
      t[0] = t[0] + 16'h1;
      if (k > 0) t[k] = t[k] + 16'h1;
      cur_time <= pack_t();
      tick;
      rdc(IDX_FLAG, (k == 0) ? 32'h0 : 32'h1 << k);
      wr(IDX_FLAG, 32'h1f);
    end
    // millisecond wrap from top to zero raises the second event
    t[0] = 16'h1023;
    cur_time <= pack_t();
    tick;
    t[0] = 16'h0;
    cur_time <= pack_t();
    tick;
    rdc(IDX_FLAG, 32'h2);
    wr(IDX_FLAG, 32'h1f);
    // wake pin as input, interrupt gate closed
    wr(IDX_PMGT, 32'h0);
    wr(IDX_IRQ_GATE, 32'h0);
    wr(IDX_EV_EN, 32'h4000);
    @(posedge clk);
    wake_i <= 1'b1;
    #1 chk1(clk_ungate, 1'b1);
    @(posedge clk);
    wake_i <= 1'b0;
    repeat (3) @(posedge clk);
    rdc(IDX_FLAG, 32'h4000);
    #1 chk1(cpu_irq, 1'b0);
    chk1(clk_on, 1'b1);
    wr(IDX_IRQ_GATE, 32'h1);
    #1 chk1(cpu_irq, 1'b1);
    wr(IDX_FLAG, 32'h4000);
    #1 chk1(cpu_irq, 1'b0);
    // pin as output: driven low while idle, wake edges ignored
    wr(IDX_PMGT, 32'h1);
    #1 chk1(wake_oe, 1'b1);
    chk1(wake_o, 1'b0);
    @(posedge clk);
    wake_i <= 1'b1;
    #1 chk1(clk_ungate, 1'b0);
    @(posedge clk);
    wake_i <= 1'b0;
    rdc(IDX_FLAG, 32'h0);
    // soft reset, then keep off the bus for the hold
    wr(IDX_OSC, 32'h1);
    repeat (3) @(posedge clk);
    rdc(IDX_PWR_LOSS, 32'h0);
    rdc(IDX_EV_EN, {16'h0, EV_EN_RST});
    close_out;
  end
endmodule : tb_rta_alarm_irq
